//--- common/isv_consts.svh
// Purpose: Constants for interrupt state save and vector logic
// Assumes: Bit n of a 32-bit word in big-endian numbering sits at index 31-n
// Notes:   Definitions only
`ifndef ISV_CONSTS_SVH
`define ISV_CONSTS_SVH

// Special-purpose register numbers
`define ISV_SPR_NC_ADDR    10'h01A
`define ISV_SPR_NC_STATE   10'h01B
`define ISV_SPR_CAUSE      10'h3D4
`define ISV_SPR_PREFIX     10'h3D6
`define ISV_SPR_CRIT_ADDR  10'h3DE
`define ISV_SPR_CRIT_STATE 10'h3DF

// Syndrome field positions (vector index)
`define ISV_ICHECK_BIT 31
`define ISV_ILL_BIT   27
`define ISV_PRIV_BIT  26
`define ISV_TRAP_BIT  25
`define ISV_STORE_BIT 23
`define ISV_ZONE_BIT  22
`define ISV_USER_BIT  15

// Implemented syndrome bits; all others read zero
`define ISV_CAUSE_MASK 32'h8EC0_8000

// Machine-check enable inside the machine state word
`define ISV_CHECK_EN_BIT 12

// Prefix field occupies the upper half
`define ISV_PREFIX_W 16

// Instruction step for the address after a system call
`define ISV_INSTR_STEP 32'h0000_0004

// Reset values
`define ISV_RST_WORD   32'h0000_0000
`define ISV_RST_PREFIX 16'h0000

`endif

//--- common/isv_pkg.sv
// Purpose: Types for interrupt state save and vector logic
// Assumes: Core sequencer classifies each exception before it is taken
// Notes:   SPR numbers and bit positions live in isv_consts.svh
package isv_pkg;

  // Kind of exception being taken
  typedef enum logic [3:0] {
    ISV_CRIT_INPUT   = 4'h0,
    ISV_MCHECK       = 4'h1,
    ISV_WATCHDOG     = 4'h2,
    ISV_DEBUG        = 4'h3,
    ISV_PROGRAM      = 4'h4,
    ISV_INSTR_STORE  = 4'h5,
    ISV_DATA_STORE   = 4'h6,
    ISV_DATA_TLB     = 4'h7,
    ISV_SYSTEM_CALL  = 4'h8,
    ISV_OTHER_NC     = 4'h9
  } isv_exc_e;

  // State of the main block apart from the reset release flops
  typedef struct packed {
    logic [31:0] ncAddr;
    logic [31:0] ncState;
    logic [31:0] critAddr;
    logic [31:0] critState;
    logic [15:0] prefix;
    logic [31:0] cause;
    logic [31:0] rdData;
    logic        rdHit;
    logic [31:0] handlerAddr;
    logic        handlerValid;
    logic [31:0] resumeAddr;
    logic [31:0] restoredState;
    logic        resumeValid;
  } isv_state_s;

endpackage

//--- design/isv_cause_gen.sv
// Purpose: Next value of the exception syndrome word
// Assumes: Flags are valid in the cycle of excTake
// Notes:   Pure combinational; hardware update beats a software write
`timescale 1ns/100ps
`include "isv_consts.svh"
module isv_cause_gen (
  input  wire logic              excTake,
  input  wire isv_pkg::isv_exc_e excKind,
  input  wire logic              instrCheckEvent,
  input  wire logic              checkEnable,
  input  wire logic              illegal,
  input  wire logic              privileged,
  input  wire logic              trap,
  input  wire logic              storeOp,
  input  wire logic              zoneViol,
  input  wire logic              noExecGuard,
  input  wire logic              userProtViol,
  input  wire logic [31:0]       oldCause,
  output logic                   causeUpdate,
  output logic [31:0]            nextCause
);
  import isv_pkg::*;

  logic [31:0] own;
  logic        uses;

  // Own bits of the taken exception; others are cleared
  always_comb begin
    own  = `ISV_RST_WORD;
    uses = 1'b0;
    if (excTake) begin
      case (excKind)
        ISV_PROGRAM: begin
          uses = 1'b1;
          own[`ISV_ILL_BIT]  = illegal;
          own[`ISV_PRIV_BIT] = privileged;
          own[`ISV_TRAP_BIT] = trap;
        end
        ISV_INSTR_STORE: begin
          uses = 1'b1;
          // Fetch from non-executable or guarded space is not a zone hit
          own[`ISV_ZONE_BIT] = zoneViol & ~noExecGuard;
        end
        ISV_DATA_STORE, ISV_DATA_TLB: begin
          uses = 1'b1;
          own[`ISV_STORE_BIT] = storeOp;
          own[`ISV_ZONE_BIT]  = zoneViol & (excKind == ISV_DATA_STORE);
          own[`ISV_USER_BIT]  = userProtViol & (excKind == ISV_DATA_STORE);
        end
        ISV_MCHECK: uses = instrCheckEvent;
        default: uses = 1'b0;
      endcase
    end
    // Instruction machine check always records, enabled or not
    own[`ISV_ICHECK_BIT] = instrCheckEvent;
    causeUpdate = uses | instrCheckEvent;
    // A pending record survives while machine checks are masked
    if (!checkEnable && oldCause[`ISV_ICHECK_BIT]) begin
      own[`ISV_ICHECK_BIT] = 1'b1;
    end
    nextCause = own & `ISV_CAUSE_MASK;
  end

endmodule

//--- design/isv_core.sv
// Purpose: Interrupt return state save, restore and handler vector forming
// Assumes: Core sequencer gives one-cycle pulses for take, return and SPR access
// Notes:   SPR reads answer one cycle later from flip-flops
//
// How it works
// - Noncritical take saves interrupted address with bits 30:31 zero.
// - Noncritical take copies whole machine state into noncritical saved state.
// - Noncritical return resumes at saved address and restores all state bits.
// - System call saves address of the following instruction.
// - Noncritical address and state registers are SPRs 0x01A and 0x01B.
// - Critical input, machine check, watchdog, debug use the critical pair.
// - Critical take saves interrupted address with bits 30:31 zero.
// - Critical take copies whole machine state into critical saved state.
// - Critical return resumes at critical address and restores all bits.
// - Watchdog saves address of the next sequential instruction.
// - Critical address and state registers are SPRs 0x3DE and 0x3DF.
// - Handler address is prefix upper 16 bits above the 16-bit offset.
// - Prefix register is SPR 0x3D6, prefix bits 0:15, rest reserved.
// - Syndrome records only program, instruction check, storage and TLB causes.
// - Instruction machine check sets syndrome bit 0.
// - Program exception sets bit 4 illegal, 5 privileged, 6 trap.
// - Store-type access causing storage or TLB fault sets bit 8.
// - Zone violation on instruction or data storage fault sets bit 9, not on TLB fault or non-executable or guarded fetch.
// - User-defined protection violation on data storage sets bit 16.
// - Syndrome-recording exception sets own bit, clears others; check bit kept while masked.
// - Syndrome register is SPR 0x3D4.
`timescale 1ns/100ps
`include "isv_consts.svh"
module isv_core (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              sprWrite,
  input  wire logic              sprRead,
  input  wire logic [9:0]        sprNum,
  input  wire logic [31:0]       sprWrData,
  output logic [31:0]            sprRdData,
  output logic                   sprHit,
  input  wire logic              excTake,
  input  wire isv_pkg::isv_exc_e excKind,
  input  wire logic [31:0]       excAddr,
  input  wire logic [15:0]       excOffset,
  input  wire logic [31:0]       machineState,
  input  wire logic              instrCheckEvent,
  input  wire logic              illegal,
  input  wire logic              privileged,
  input  wire logic              trap,
  input  wire logic              storeOp,
  input  wire logic              zoneViol,
  input  wire logic              noExecGuard,
  input  wire logic              userProtViol,
  input  wire logic              returnNc,
  input  wire logic              returnCrit,
  output logic [31:0]            handlerAddr,
  output logic                   handlerValid,
  output logic [31:0]            resumeAddr,
  output logic [31:0]            restoredState,
  output logic                   resumeValid
);
  import isv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rstPipe;
  logic       rstSync_b;

  // Assert at once, release after two edges to avoid a ragged exit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSync_b = rstPipe[1];

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Critical kinds use the second save pair
  function automatic logic isCritical(input isv_exc_e kind);
    case (kind)
      ISV_CRIT_INPUT, ISV_MCHECK, ISV_WATCHDOG, ISV_DEBUG: isCritical = 1'b1;
      default: isCritical = 1'b0;
    endcase
  endfunction

  // True when the SPR number names a register of this block
  function automatic logic sprMapped(input logic [9:0] num);
    case (num)
      `ISV_SPR_NC_ADDR, `ISV_SPR_NC_STATE, `ISV_SPR_CAUSE,
      `ISV_SPR_PREFIX, `ISV_SPR_CRIT_ADDR, `ISV_SPR_CRIT_STATE: sprMapped = 1'b1;
      default: sprMapped = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Syndrome next value

  isv_state_s  st;
  isv_state_s  next_st;
  logic        causeUpdate;
  logic [31:0] hwCause;
  logic        takeCrit;
  logic        takeNc;
  logic [31:0] saveAddr;

  isv_cause_gen u_cause (
    .excTake      (excTake),
    .excKind      (excKind),
    .instrCheckEvent (instrCheckEvent),
    .checkEnable  (machineState[`ISV_CHECK_EN_BIT]),
    .illegal      (illegal),
    .privileged   (privileged),
    .trap         (trap),
    .storeOp      (storeOp),
    .zoneViol     (zoneViol),
    .noExecGuard  (noExecGuard),
    .userProtViol (userProtViol),
    .oldCause     (st.cause),
    .causeUpdate  (causeUpdate),
    .nextCause    (hwCause)
  );

  // Route and return address of the taken exception
  assign takeCrit = excTake & isCritical(excKind);
  assign takeNc   = excTake & ~isCritical(excKind);
  // Only a system call steps past itself; async kinds already give the next one
  assign saveAddr = (excKind == ISV_SYSTEM_CALL) ? excAddr + `ISV_INSTR_STEP : excAddr;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Software writes first, hardware events override in the same cycle
  always_comb begin
    next_st              = st;
    next_st.handlerValid = 1'b0;
    next_st.resumeValid  = 1'b0;
    next_st.rdHit        = 1'b0;
    // Writes through move-to-SPR
    if (sprWrite) begin
      case (sprNum)
        `ISV_SPR_NC_ADDR:    next_st.ncAddr    = {sprWrData[31:2], 2'b00};
        `ISV_SPR_NC_STATE:   next_st.ncState   = sprWrData;
        `ISV_SPR_CRIT_ADDR:  next_st.critAddr  = {sprWrData[31:2], 2'b00};
        `ISV_SPR_CRIT_STATE: next_st.critState = sprWrData;
        `ISV_SPR_PREFIX:     next_st.prefix    = sprWrData[31:16];
        `ISV_SPR_CAUSE:      next_st.cause     = sprWrData & `ISV_CAUSE_MASK;
        default: next_st.rdHit = 1'b0;
      endcase
    end
    // Reads through move-from-SPR; reserved halves read zero
    if (sprRead) begin
      next_st.rdHit = sprMapped(sprNum);
      case (sprNum)
        `ISV_SPR_NC_ADDR:    next_st.rdData = st.ncAddr;
        `ISV_SPR_NC_STATE:   next_st.rdData = st.ncState;
        `ISV_SPR_CRIT_ADDR:  next_st.rdData = st.critAddr;
        `ISV_SPR_CRIT_STATE: next_st.rdData = st.critState;
        `ISV_SPR_PREFIX:     next_st.rdData = {st.prefix, 16'h0000};
        `ISV_SPR_CAUSE:      next_st.rdData = st.cause;
        default:             next_st.rdData = `ISV_RST_WORD;
      endcase
    end
    // A hardware event in the cycle of a write keeps the event
    if (causeUpdate) begin
      next_st.cause = hwCause;
    end
    if (takeNc) begin
      next_st.ncAddr  = {saveAddr[31:2], 2'b00};
      next_st.ncState = machineState;
    end
    if (takeCrit) begin
      next_st.critAddr  = {saveAddr[31:2], 2'b00};
      next_st.critState = machineState;
    end
    // Handler address from prefix and offset
    if (excTake) begin
      next_st.handlerAddr  = {st.prefix, excOffset};
      next_st.handlerValid = 1'b1;
    end else if (returnNc) begin
      next_st.resumeAddr    = st.ncAddr;
      next_st.restoredState = st.ncState;
      next_st.resumeValid   = 1'b1;
    end else if (returnCrit) begin
      next_st.resumeAddr    = st.critAddr;
      next_st.restoredState = st.critState;
      next_st.resumeValid   = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Saved words clear at reset; software sets them up before use
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st.ncAddr        <= `ISV_RST_WORD;
      st.ncState       <= `ISV_RST_WORD;
      st.critAddr      <= `ISV_RST_WORD;
      st.critState     <= `ISV_RST_WORD;
      st.prefix        <= `ISV_RST_PREFIX;
      st.cause         <= `ISV_RST_WORD;
      st.rdData        <= `ISV_RST_WORD;
      st.rdHit         <= 1'b0;
      st.handlerAddr   <= `ISV_RST_WORD;
      st.handlerValid  <= 1'b0;
      st.resumeAddr    <= `ISV_RST_WORD;
      st.restoredState <= `ISV_RST_WORD;
      st.resumeValid   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign sprRdData     = st.rdData;
  assign sprHit        = st.rdHit;
  assign handlerAddr   = st.handlerAddr;
  assign handlerValid  = st.handlerValid;
  assign resumeAddr    = st.resumeAddr;
  assign restoredState = st.restoredState;
  assign resumeValid   = st.resumeValid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstSync_b);

  AST_NC_ADDR: assert property (
    takeNc && excKind != ISV_SYSTEM_CALL |=> st.ncAddr == {$past(excAddr[31:2]), 2'b00})
    else $error("noncritical address not saved");

  AST_NC_STATE: assert property (
    takeNc |=> st.ncState == $past(machineState))
    else $error("noncritical state not saved");

  AST_NC_RETURN: assert property (
    returnNc && !excTake |=> resumeValid && resumeAddr == $past(st.ncAddr)
      && restoredState == $past(st.ncState))
    else $error("noncritical return wrong");

  AST_SYSCALL: assert property (
    takeNc && excKind == ISV_SYSTEM_CALL
      |=> st.ncAddr == {$past(excAddr[31:2]) + 30'h0000_0001, 2'b00})
    else $error("system call return address wrong");

  AST_CRIT_PAIR: assert property (
    excTake && excKind == ISV_WATCHDOG |=> $stable(st.ncState) && st.critState == $past(machineState))
    else $error("critical kind used wrong pair");

  AST_CRIT_ADDR: assert property (
    takeCrit |=> st.critAddr == {$past(excAddr[31:2]), 2'b00})
    else $error("critical address not saved or misaligned");

  AST_CRIT_RETURN: assert property (
    returnCrit && !returnNc && !excTake |=> resumeValid && resumeAddr == $past(st.critAddr)
      && restoredState == $past(st.critState))
    else $error("critical return wrong");

  AST_VECTOR: assert property (
    excTake |=> handlerValid && handlerAddr == {$past(st.prefix), $past(excOffset)})
    else $error("handler address wrong");

  AST_PREFIX_READ: assert property (
    sprRead && sprNum == `ISV_SPR_PREFIX |=> sprHit && sprRdData[15:0] == 16'h0000)
    else $error("prefix reserved bits not zero");

  AST_NO_CAUSE: assert property (
    excTake && isCritical(excKind) && excKind != ISV_MCHECK && !instrCheckEvent && !sprWrite
      |=> $stable(st.cause))
    else $error("syndrome changed by unrelated kind");

  AST_ICHECK_SET: assert property (
    instrCheckEvent |=> st.cause[`ISV_ICHECK_BIT])
    else $error("instruction check bit not set");

  AST_PROG_BITS: assert property (
    excTake && excKind == ISV_PROGRAM && illegal && !trap |=> st.cause[`ISV_ILL_BIT]
      && !st.cause[`ISV_TRAP_BIT])
    else $error("program cause bits wrong");

  AST_ZONE_GUARD: assert property (
    excTake && excKind == ISV_INSTR_STORE && noExecGuard |=> !st.cause[`ISV_ZONE_BIT])
    else $error("zone bit set on guarded fetch");

  AST_ICHECK_KEEP: assert property (
    excTake && excKind == ISV_DATA_STORE && !machineState[`ISV_CHECK_EN_BIT] && st.cause[`ISV_ICHECK_BIT]
      |=> st.cause[`ISV_ICHECK_BIT] && !st.cause[`ISV_ILL_BIT])
    else $error("masked check record lost");

  AST_RESERVED: assert property (
    (st.cause & ~`ISV_CAUSE_MASK) == `ISV_RST_WORD)
    else $error("reserved syndrome bit set");

endmodule

//--- testbench/isv_testbench.sv
// Purpose: Self-checking bench for interrupt state save, restore and vector forming
// Assumes: One-cycle strobes, answers one cycle after the taking edge
// Notes:   Inputs change on the falling edge; outputs are checked at the next falling edge
`timescale 1ns/100ps
`include "isv_consts.svh"
module testbench;
  import isv_pkg::*;
  logic        clock, rst_b, sprWrite, sprRead, excTake, returnNc, returnCrit, sprHit, handlerValid, resumeValid;
  logic [9:0]  sprNum;
  logic [31:0] sprWrData, sprRdData, excAddr, machineState, handlerAddr, resumeAddr, restoredState;
  logic [15:0] excOffset;
  logic [7:0]  flags;
  isv_exc_e    excKind;
  int          mismatches, check_count, i;
  logic [31:0] addr, ms;
  logic [9:0]  sprTab [6];
  logic [31:0] onesExp [6];
  isv_exc_e    kindTab [7];
  logic [7:0]  flagTab [7];
  logic [31:0] causeTab [7];
  isv_exc_e    critTab [4];

  isv_core dut_u (.clock(clock), .rst_b(rst_b), .sprWrite(sprWrite), .sprRead(sprRead), .sprNum(sprNum),
    .sprWrData(sprWrData), .sprRdData(sprRdData), .sprHit(sprHit), .excTake(excTake), .excKind(excKind),
    .excAddr(excAddr), .excOffset(excOffset), .machineState(machineState), .instrCheckEvent(flags[7]),
    .illegal(flags[6]), .privileged(flags[5]), .trap(flags[4]), .storeOp(flags[3]), .zoneViol(flags[2]),
    .noExecGuard(flags[1]), .userProtViol(flags[0]), .returnNc(returnNc), .returnCrit(returnCrit),
    .handlerAddr(handlerAddr), .handlerValid(handlerValid), .resumeAddr(resumeAddr),
    .restoredState(restoredState), .resumeValid(resumeValid));

  // Free-running core clock
  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, report and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Access tasks; each waits a falling edge first so no strobe is driven twice in one step
  task automatic spr_wr(input logic [9:0] num, input logic [31:0] data);
    @(negedge clock);
    sprNum = num;
    sprWrData = data;
    sprWrite = 1'b1;
    @(negedge clock);
    sprWrite = 1'b0;
  endtask

  task automatic spr_rd(input logic [9:0] num, input logic [31:0] exp, input logic expHit);
    @(negedge clock);
    sprNum = num;
    sprRead = 1'b1;
    @(negedge clock);
    sprRead = 1'b0;
    check(sprRdData, exp);
    check({31'h0000_0000, sprHit}, {31'h0000_0000, expHit});
  endtask

  task automatic exc(input logic tk, input isv_exc_e kind, input logic [31:0] a, input logic [15:0] off,
                     input logic [7:0] fl, input logic [31:0] expH);
    @(negedge clock);
    excTake = tk;
    excKind = kind;
    excAddr = a;
    excOffset = off;
    flags = fl;
    @(negedge clock);
    excTake = 1'b0;
    flags = 8'h00;
    if (tk) begin
      check({31'h0000_0000, handlerValid}, 32'h0000_0001);
      check(handlerAddr, expH);
    end
  endtask

  task automatic ret(input logic nc, input logic [31:0] expA, input logic [31:0] expS);
    @(negedge clock);
    returnNc = nc;
    returnCrit = ~nc;
    @(negedge clock);
    returnNc = 1'b0;
    returnCrit = 1'b0;
    check({31'h0000_0000, resumeValid}, 32'h0000_0001);
    check(resumeAddr, expA);
    check(restoredState, expS);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard: a run far longer than the sequence counts as a failure
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    clock = 1'b0; rst_b = 1'b1; sprWrite = 1'b0; sprRead = 1'b0; sprNum = 10'h000;
    sprWrData = 32'h0000_0000; excTake = 1'b0; excKind = ISV_OTHER_NC; excAddr = 32'h0000_0000;
    excOffset = 16'h0000; machineState = 32'h0000_0000; flags = 8'h00; returnNc = 1'b0; returnCrit = 1'b0;
    mismatches = 0; check_count = 0;
    sprTab = '{`ISV_SPR_NC_ADDR, `ISV_SPR_NC_STATE, `ISV_SPR_CAUSE, `ISV_SPR_PREFIX, `ISV_SPR_CRIT_ADDR,
               `ISV_SPR_CRIT_STATE};
    onesExp = '{32'hFFFF_FFFC, 32'hFFFF_FFFF, 32'h8EC0_8000, 32'hFFFF_0000, 32'hFFFF_FFFC, 32'hFFFF_FFFF};
    kindTab = '{ISV_PROGRAM, ISV_PROGRAM, ISV_PROGRAM, ISV_DATA_STORE, ISV_DATA_TLB, ISV_INSTR_STORE,
                ISV_INSTR_STORE};
    flagTab = '{8'h40, 8'h20, 8'h10, 8'h0D, 8'h08, 8'h06, 8'h04};
    causeTab = '{32'h0800_0000, 32'h0400_0000, 32'h0200_0000, 32'h00C0_8000, 32'h0080_0000, 32'h0000_0000,
                 32'h0040_0000};
    critTab = '{ISV_CRIT_INPUT, ISV_MCHECK, ISV_WATCHDOG, ISV_DEBUG};
    // Drop reset after time zero so the asynchronous reset edge is never missed
    #1 rst_b = 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(posedge clock);
    // Reset values, then all-ones write showing forced and reserved bits
    for (i = 0; i < 6; i++) spr_rd(sprTab[i], 32'h0000_0000, 1'b1);
    for (i = 0; i < 6; i++) spr_wr(sprTab[i], 32'hFFFF_FFFF);
    for (i = 0; i < 6; i++) spr_rd(sprTab[i], onesExp[i], 1'b1);
    spr_wr(10'h3D5, 32'h1234_5678);
    spr_rd(10'h3D5, 32'h0000_0000, 1'b0);
    spr_wr(`ISV_SPR_PREFIX, 32'h1234_5678);
    spr_wr(`ISV_SPR_CAUSE, 32'h0000_0000);
    // Noncritical takes with every recorded cause; low address bits must be dropped
    for (i = 0; i < 7; i++) begin
      addr = 32'h0000_1003 + i * 32'h0000_0100;
      ms = 32'hA5A5_4A50 + i;
      machineState = ms;
      exc(1'b1, kindTab[i], addr, 16'h0700, flagTab[i], 32'h1234_0700);
      spr_rd(`ISV_SPR_NC_ADDR, addr & 32'hFFFF_FFFC, 1'b1);
      spr_rd(`ISV_SPR_NC_STATE, ms, 1'b1);
      spr_rd(`ISV_SPR_CAUSE, causeTab[i], 1'b1);
    end
    spr_rd(`ISV_SPR_CRIT_ADDR, 32'hFFFF_FFFC, 1'b1);
    // System call saves the following address and leaves the syndrome alone
    exc(1'b1, ISV_SYSTEM_CALL, 32'h0000_2000, 16'h0C00, 8'h00, 32'h1234_0C00);
    spr_rd(`ISV_SPR_NC_ADDR, 32'h0000_2004, 1'b1);
    spr_rd(`ISV_SPR_CAUSE, 32'h0040_0000, 1'b1);
    // Instruction check bit survives other causes only while checks are masked
    machineState = 32'h0000_0000;
    exc(1'b0, ISV_OTHER_NC, 32'h0000_0000, 16'h0000, 8'h80, 32'h0000_0000);
    spr_rd(`ISV_SPR_CAUSE, 32'h8000_0000, 1'b1);
    exc(1'b1, ISV_DATA_STORE, 32'h0000_5000, 16'h0700, 8'h08, 32'h1234_0700);
    spr_rd(`ISV_SPR_CAUSE, 32'h8080_0000, 1'b1);
    machineState = 32'h0000_1000;
    exc(1'b1, ISV_PROGRAM, 32'h0000_5000, 16'h0700, 8'h20, 32'h1234_0700);
    spr_rd(`ISV_SPR_CAUSE, 32'h0400_0000, 1'b1);
    // Every critical kind uses the critical pair only
    for (i = 0; i < 4; i++) begin
      addr = 32'h0000_4001 + i * 32'h0000_0040;
      ms = 32'h1357_0000 + i;
      machineState = ms;
      exc(1'b1, critTab[i], addr, 16'h0100, 8'h00, 32'h1234_0100);
      spr_rd(`ISV_SPR_CRIT_ADDR, addr & 32'hFFFF_FFFC, 1'b1);
      spr_rd(`ISV_SPR_CRIT_STATE, ms, 1'b1);
    end
    spr_rd(`ISV_SPR_NC_ADDR, 32'h0000_5000, 1'b1);
    spr_rd(`ISV_SPR_CAUSE, 32'h0400_0000, 1'b1);
    // Returns, including one from software-written saved values
    ret(1'b1, 32'h0000_5000, 32'h0000_1000);
    ret(1'b0, 32'h0000_4000 + 32'h0000_00C0, 32'h1357_0003);
    spr_wr(`ISV_SPR_NC_STATE, 32'hDEAD_BEEF);
    spr_wr(`ISV_SPR_NC_ADDR, 32'h0000_6007);
    ret(1'b1, 32'h0000_6004, 32'hDEAD_BEEF);
    close_out();
  end
endmodule
